//--- common/rtc_pkg.sv
package rtc_pkg;

  localparam int unsigned DAY_W   = 16;
  localparam int unsigned PRE_W   = 17;
  localparam int unsigned CD_W    = 8;
  localparam int unsigned SMP_W   = 8;

  // Reference edges per second for each crystal choice
  localparam logic [PRE_W-1:0] DIV_32K768 = 17'h08000;
  localparam logic [PRE_W-1:0] DIV_32K000 = 17'h07D00;
  localparam logic [PRE_W-1:0] DIV_38K400 = 17'h09600;

  // Last sampling timer count; the period is 256 reference edges
  localparam logic [SMP_W-1:0] SMP_LAST   = 8'hFF;

  // Last value before each counter wraps
  localparam logic [5:0] SEC_LAST  = 6'h3B;
  localparam logic [5:0] MIN_LAST  = 6'h3B;
  localparam logic [5:0] HOUR_LAST = 6'h17;

  localparam logic [PRE_W-1:0] PRE_RESET = 17'h00000;
  localparam logic [SMP_W-1:0] SMP_RESET = 8'h00;
  localparam logic [CD_W-1:0]  CD_RESET  = 8'h00;

  typedef enum logic [1:0] {
    RTC_REF_32K768,
    RTC_REF_32K000,
    RTC_REF_38K400
  } rtc_ref_t;

  typedef struct packed {
    logic [DAY_W-1:0] days;
    logic [5:0]       hours;
    logic [5:0]       minutes;
    logic [5:0]       seconds;
  } rtc_time_t;

  localparam rtc_time_t TIME_RESET = '0;

  typedef struct packed {
    logic alarm;
    logic countdown;
    logic sample;
    logic day;
    logic hour;
    logic minute;
    logic second;
  } rtc_evt_t;

  localparam rtc_evt_t EVT_RESET = '0;

endpackage

//--- design/rtc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_edge_sync
(
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // Asynchronous pin
  input  wire logic PIN,
  // Rising edge pulse
  output logic      RISE
);

  logic s1;
  logic s2;
  logic s3;
  logic level;
  logic next_level;
  logic next_rise;

  // Level moves only when the second and third stages agree
  always_comb
  begin
    next_level = level;
    next_rise  = 1'b0;
    if (s2 == s3 && s2 != level)
    begin
      next_level = s2;
      next_rise  = s2;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      RISE  <= 1'b0;
    end
    else
    begin
      s1    <= PIN;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
      RISE  <= next_rise;
    end
  end

endmodule

`default_nettype wire

//--- design/rtc_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Prescaler divides crystal reference edges down to a one-second tick.
// RULE2: Divider follows crystal choice: 32.768, 32 or 38.4 kHz, exact.
// RULE3: Seconds, minutes, hours and days counters advance on the tick.
// RULE4: Enabled daily alarm pulses when the time matches the alarm setting.
// RULE5: Minute countdown loads a value and pulses on reaching zero.
// RULE6: Sampling timer pulses at a fixed reference-derived rate.
// RULE7: Separate pulses on each second, minute, hour and day boundary.
// RULE8: Seconds and minutes wrap after 59, hours after 23, carrying upward.

module rtc_top
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // Crystal reference pin and its choice
  input  wire logic                 REF_CLK,
  input  wire rtc_pkg::rtc_ref_t    REF_SEL,
  // Time setting
  input  wire logic                 TIME_LOAD,
  input  wire rtc_pkg::rtc_time_t   TIME_IN,
  // Daily alarm
  input  wire logic                 ALARM_EN,
  input  wire rtc_pkg::rtc_time_t   ALARM_TIME,
  // Minute countdown
  input  wire logic                 CD_LOAD,
  input  wire logic [rtc_pkg::CD_W-1:0] CD_MINUTES,
  output logic [rtc_pkg::CD_W-1:0]  CD_REMAIN,
  // Current time and events
  output rtc_pkg::rtc_time_t        TIME_OUT,
  output rtc_pkg::rtc_evt_t         EVENTS
);

  import rtc_pkg::*;

  // Reference side
  logic             ref_rise;
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic [SMP_W-1:0] smp;
  logic [SMP_W-1:0] next_smp;
  logic             tick;

  // Carries between the counter groups
  logic             sec_roll;
  logic             min_roll;
  logic             hour_roll;
  logic             cd_fire;

  rtc_time_t        next_time;
  rtc_evt_t         next_evt;
  logic [CD_W-1:0]  next_cd;

  // Edge of wrapping counter: returns {carry, next value}
  function automatic logic [6:0] step_wrap(input logic [5:0] v,
                                           input logic [5:0] last);
    if (v >= last)
      step_wrap = {1'b1, 6'h00};
    else
      step_wrap = {1'b0, v + 6'h01};
  endfunction

  // Unused choice falls back to the 32.768 kHz divider
  function automatic logic [PRE_W-1:0] ref_div(input rtc_ref_t sel);
    case (sel)
      RTC_REF_32K000: ref_div = DIV_32K000;
      RTC_REF_38K400: ref_div = DIV_38K400;
      default:        ref_div = DIV_32K768;
    endcase
  endfunction

  // Reference pin is not trusted until the second and third stages agree
  rtc_edge_sync u_ref_sync
  (
    .CLK  (CLK),
    .RST  (RST),
    .PIN  (REF_CLK),
    .RISE (ref_rise)
  );

  // Prescaler; a load restarts it and drops a tick due that cycle
  always_comb
  begin
    next_pre = pre;
    tick     = 1'b0;
    if (TIME_LOAD)
      next_pre = PRE_RESET;
    else if (ref_rise)
    begin
      // Compare to last count so a smaller divider never overshoots
      if (pre >= ref_div(REF_SEL) - 17'h00001) // RULE2
      begin
        next_pre = PRE_RESET;
        tick     = 1'b1; // RULE1
      end
      else
        next_pre = pre + 17'h00001;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      pre <= PRE_RESET;
    else
      pre <= next_pre;
  end

  // Sampling divider runs free of time loads
  always_comb
  begin
    next_smp = smp;
    if (ref_rise)
      next_smp = (smp == SMP_LAST) ? SMP_RESET : smp + 8'h01; // RULE6
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      smp <= SMP_RESET;
    else
      smp <= next_smp;
  end

  // Time of day counters; out-of-range loads wrap on the next step
  always_comb
  begin
    logic [6:0] s;
    logic [6:0] m;
    logic [6:0] h;
    s         = step_wrap(TIME_OUT.seconds, SEC_LAST); // RULE8
    m         = step_wrap(TIME_OUT.minutes, MIN_LAST); // RULE8
    h         = step_wrap(TIME_OUT.hours, HOUR_LAST); // RULE8
    next_time = TIME_OUT;
    sec_roll  = 1'b0;
    min_roll  = 1'b0;
    hour_roll = 1'b0;
    if (TIME_LOAD)
      next_time = TIME_IN;
    else if (tick)
    begin
      next_time.seconds = s[5:0]; // RULE3
      sec_roll          = s[6];
      if (s[6])
      begin
        next_time.minutes = m[5:0]; // RULE3
        min_roll          = m[6];
        if (m[6])
        begin
          next_time.hours = h[5:0]; // RULE3
          hour_roll       = h[6];
          if (h[6])
            next_time.days = TIME_OUT.days + 16'h0001; // RULE3
        end
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      TIME_OUT <= TIME_RESET;
    else
      TIME_OUT <= next_time;
  end

  // Countdown steps on each minute roll; a load wins over the step
  always_comb
  begin
    next_cd = CD_REMAIN;
    cd_fire = 1'b0;
    if (CD_LOAD)
      next_cd = CD_MINUTES;
    // A loaded zero stays idle and never fires
    else if (sec_roll && CD_REMAIN != CD_RESET)
    begin
      next_cd = CD_REMAIN - 8'h01; // RULE5
      cd_fire = CD_REMAIN == 8'h01; // RULE5
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      CD_REMAIN <= CD_RESET;
    else
      CD_REMAIN <= next_cd;
  end

  // Boundary pulses share the cycle of the second that causes them
  always_comb
  begin
    next_evt           = EVT_RESET;
    next_evt.sample    = ref_rise && smp == SMP_LAST; // RULE6
    next_evt.second    = tick; // RULE7
    next_evt.minute    = sec_roll; // RULE7
    next_evt.hour      = min_roll; // RULE7
    next_evt.day       = hour_roll; // RULE7
    next_evt.countdown = cd_fire; // RULE5
    // Days ignored so the match repeats every day
    next_evt.alarm     = tick && ALARM_EN
      && next_time.hours == ALARM_TIME.hours
      && next_time.minutes == ALARM_TIME.minutes
      && next_time.seconds == ALARM_TIME.seconds; // RULE4
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      EVENTS <= EVT_RESET;
    else
      EVENTS <= next_evt;
  end

endmodule

`default_nettype wire

//--- test/rtc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_monitor
  import rtc_pkg::*;
(
  // Clock, reset
  input wire logic                  CLK,
  input wire logic                  RST,
  // Watched ports
  input wire logic                  TIME_LOAD,
  input wire rtc_pkg::rtc_time_t    TIME_IN,
  input wire logic                  ALARM_EN,
  input wire rtc_pkg::rtc_time_t    ALARM_TIME,
  input wire logic [CD_W-1:0]       CD_REMAIN,
  input wire rtc_pkg::rtc_time_t    TIME_OUT,
  input wire rtc_pkg::rtc_evt_t     EVENTS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_min_sec: assert property (EVENTS.minute |-> EVENTS.second)
    else $error("minute pulse alone");
  a_day_hour: assert property (EVENTS.day |-> EVENTS.hour)
    else $error("day pulse alone");
  a_min_carry: assert property (EVENTS.minute |-> TIME_OUT.seconds == 6'h00)
    else $error("seconds not wrapped");
  a_hour_carry: assert property (EVENTS.hour |-> TIME_OUT.minutes == 6'h00)
    else $error("minutes not wrapped");
  a_day_carry: assert property (EVENTS.day |-> TIME_OUT.hours == 6'h00
    && TIME_OUT.days == $past(TIME_OUT.days) + 16'h0001)
    else $error("day carry wrong");
  a_cd_fire: assert property (EVENTS.countdown |-> EVENTS.minute
    && CD_REMAIN == 8'h00 && $past(CD_REMAIN) == 8'h01)
    else $error("countdown pulse wrong");
  a_alarm_hit: assert property (EVENTS.alarm |-> $past(ALARM_EN)
    && TIME_OUT[17:0] == $past(ALARM_TIME[17:0]))
    else $error("alarm pulse wrong");
  a_time_load: assert property (TIME_LOAD |=> TIME_OUT == $past(TIME_IN))
    else $error("load not taken");
endmodule
bind rtc_top rtc_monitor u_mon (.CLK, .RST, .TIME_LOAD, .TIME_IN,
  .ALARM_EN, .ALARM_TIME, .CD_REMAIN, .TIME_OUT, .EVENTS);
`default_nettype wire

//--- test/rtc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_top_bench;
  import rtc_pkg::*;
  logic            clk;
  logic            rst;
  logic            ref_clk;
  logic            ref_run;
  logic            ref_ph;
  logic            tld;
  rtc_time_t       tin;
  logic            cld;
  logic [CD_W-1:0] cdm;
  logic [CD_W-1:0] cdr;
  rtc_time_t       tout;
  rtc_evt_t        ev;
  int              err_count;
  int              tests_run;

  rtc_top dut
  (
    .CLK        (clk),
    .RST        (rst),
    .REF_CLK    (ref_clk),
    .REF_SEL    (RTC_REF_32K000),
    .TIME_LOAD  (tld),
    .TIME_IN    (tin),
    .ALARM_EN   (1'b1),
    .ALARM_TIME (34'h0),
    .CD_LOAD    (cld),
    .CD_MINUTES (cdm),
    .CD_REMAIN  (cdr),
    .TIME_OUT   (tout),
    .EVENTS     (ev)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Each level spans two samples so the synchroniser resolves it
  always @(posedge clk)
    if (ref_run)
    begin
      ref_ph  <= #1 ~ref_ph;
      ref_clk <= #1 ref_clk ^ ref_ph;
    end

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        err_count++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task automatic conclude;
    begin
      if (err_count == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Load 23:59:59 and a one-minute countdown
  task automatic t_load;
    begin
      tld = 1'b1;
      tin = {16'h0005, 6'h17, 6'h3B, 6'h3B};
      cld = 1'b1;
      cdm = 8'h01;
      @(posedge clk);
      #1;
      tld = 1'b0;
      cld = 1'b0;
      ref_run = 1'b1;
      cmp(tout, tin);
      cmp(cdr, 8'h01);
    end
  endtask

  // One second of 32 kHz edges rolls every field
  task automatic t_tick;
    int n;
    int s;
    begin
      n = 0;
      s = 0;
      while (ev.second !== 1'b1 && n < 135000)
      begin
        @(posedge clk);
        #1;
        n++;
        s += (ev.sample === 1'b1);
      end
      cmp(n >= 127990 && n <= 128010, 1);
      cmp(s >= 124 && s <= 125, 1);
      cmp(ev & 7'h6F, 7'h6F);
      cmp(tout, {16'h0006, 18'h0});
      cmp(cdr, 8'h00);
      @(posedge clk);
      #1;
      cmp(ev & 7'h6F, 7'h00);
    end
  endtask

  initial
  begin
    repeat (140000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial
  begin
    {rst, ref_clk, ref_run, tld, cld} = 5'h10;
    ref_ph = 1'b0;
    tin = '0;
    cdm = 8'h00;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_load();
    t_tick();
    conclude();
  end
endmodule
`default_nettype wire
